/* File: core/spi_fault_pkg.sv */
package spi_fault_pkg;

  // ==========================================================
  // Frame layout
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam int RW_POS = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 9;
  localparam int PAR_POS = 8;

  // ==========================================================
  // Device register map
  localparam logic [5:0] ADDR_CHIP = 6'h00;
  localparam logic [5:0] ADDR_STAT1 = 6'h01;
  localparam logic [5:0] ADDR_SECOND_STATUS_REG = 6'h02;
  localparam logic [5:0] ADDR_CTRL = 6'h03;
  localparam logic [5:0] ADDR_MAX = 6'h0c;
  localparam int CFG_FIRST = 3;
  localparam int CFG_LAST = 12;
  localparam logic [7:0] REG_DEFAULT = 8'h00;

  // Control register fields
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_WREP_BIT = 1;
  localparam int CTRL_LOCK_LO = 2;
  localparam logic [1:0] LOCK_LATCH = 2'h0;
  localparam logic [1:0] LOCK_OFF = 2'h3;

  // Status fields
  localparam int CHIP_STALL = 7;
  localparam int CHIP_SPI = 5;
  localparam int CHIP_THERM = 1;
  localparam int CHIP_FAULT = 0;
  localparam int STAT1_WARN = 7;
  localparam int STAT1_SHUT = 6;
  localparam int SECOND_STATUS_REG_FRAME = 1;
  localparam int SECOND_STATUS_REG_ADDR = 0;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_RST_NS = 1000;
  localparam int T_SLEEP_NS = 2000;
  localparam int T_WAKE_NS = 2000;
  localparam int T_CS_GAP_NS = 400;
  localparam int T_SCLK_HALF_NS = 80;
  localparam logic [9:0] RST_CYC = 10'(T_RST_NS / CLK_PERIOD_NS);
  localparam logic [9:0] SLEEP_CYC =
    10'((T_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] WAKE_CYC =
    10'((T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] GAP_CYC =
    10'((T_CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] HALF_CYC =
    10'((T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Controller command registers
  localparam logic [1:0] CREG_TX = 2'h0;
  localparam logic [1:0] CREG_RX = 2'h1;
  localparam logic [1:0] CREG_STAT = 2'h2;
  localparam logic [1:0] CREG_SLEEP = 2'h3;

  // ==========================================================
  // State machines
  typedef enum logic [3:0] {
    PWR_RUN = 4'h1,
    PWR_LOW = 4'h2,
    PWR_SLEEP = 4'h4,
    PWR_WAKE = 4'h8
  } pwr_state_t;

  typedef enum logic [5:0] {
    LNK_IDLE = 6'h01,
    LNK_LEAD = 6'h02,
    LNK_HIGH = 6'h04,
    LNK_LOW = 6'h08,
    LNK_TRAIL = 6'h10,
    LNK_GAP = 6'h20
  } link_state_t;

endpackage

/* File: core/spi_link_if.sv */
`timescale 1ns/1ns
// ============================================================
// Serial link between controller and device
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sleep_n;

  modport device (input cs_n, input sclk, input sdi, input sleep_n,
                  output sdo, output sdo_oe);
  modport ctrl (output cs_n, output sclk, output sdi, output sleep_n,
                input sdo, input sdo_oe);
endinterface

/* File: core/spi_fault_device.sv */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module spi_fault_device (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Serial link
  spi_link_if.device LINK,
  // Condition pins
  input wire logic DRV_DISABLE_I,
  input wire logic THERM_WARN_I,
  input wire logic THERM_SHUT_I,
  input wire logic LOCK_EVENT_I,
  // Power and fault outputs
  output logic FAULT_N_O,
  output logic SWITCH_EN_O,
  output logic PUMP_EN_O,
  output logic SUPPLY_EN_O,
  output logic SLEEPING_O
);

  // ==========================================================
  // Input synchronisers
  logic [7:0] in_meta;
  logic [7:0] in_sync;
  logic sclk_d;
  logic cs_n_d;
  wire logic cs_n_s = in_sync[0];
  wire logic sclk_s = in_sync[1];
  wire logic sdi_s = in_sync[2];
  wire logic sleep_s = in_sync[3];
  wire logic drv_s = in_sync[4];
  wire logic warn_s = in_sync[5];
  wire logic shut_s = in_sync[6];
  wire logic lock_s = in_sync[7];

  // Two flops per pin, then edge history
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      in_meta <= 8'h09;
      in_sync <= 8'h09;
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      in_meta <= {LOCK_EVENT_I, THERM_SHUT_I, THERM_WARN_I, DRV_DISABLE_I,
                  LINK.sleep_n, LINK.sdi, LINK.sclk, LINK.cs_n};
      in_sync <= in_meta;
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  // ==========================================================
  // Power state
  spi_fault_pkg::pwr_state_t pwr;
  logic [9:0] pwr_cnt;
  logic link_en;
  logic rst_pulse;
  logic in_transition;

  assign link_en = (pwr == spi_fault_pkg::PWR_RUN) ||
                   (pwr == spi_fault_pkg::PWR_LOW);
  // Short low phase ends as a clear pulse
  assign rst_pulse = (pwr == spi_fault_pkg::PWR_LOW) && sleep_s &&
                     (pwr_cnt <= spi_fault_pkg::RST_CYC);
  assign in_transition = ((pwr == spi_fault_pkg::PWR_LOW) &&
                          (pwr_cnt > spi_fault_pkg::RST_CYC)) ||
                         (pwr == spi_fault_pkg::PWR_WAKE);

  // Sleep entry, reset pulse and wake sequencing
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pwr <= spi_fault_pkg::PWR_RUN;
      pwr_cnt <= 10'h000;
    end else begin
      case (pwr)
        spi_fault_pkg::PWR_RUN: begin
          pwr_cnt <= 10'h000;
          if (!sleep_s) begin
            pwr <= spi_fault_pkg::PWR_LOW;
          end
        end
        spi_fault_pkg::PWR_LOW: begin
          pwr_cnt <= pwr_cnt + 10'h001;
          if (sleep_s) begin
            pwr_cnt <= 10'h000;
            pwr <= (pwr_cnt <= spi_fault_pkg::RST_CYC) ?
                   spi_fault_pkg::PWR_RUN : spi_fault_pkg::PWR_WAKE;
          end else if (pwr_cnt == spi_fault_pkg::SLEEP_CYC) begin
            pwr <= spi_fault_pkg::PWR_SLEEP;
          end
        end
        spi_fault_pkg::PWR_SLEEP: begin
          pwr_cnt <= 10'h000;
          if (sleep_s) begin
            pwr <= spi_fault_pkg::PWR_WAKE;
          end
        end
        spi_fault_pkg::PWR_WAKE: begin
          pwr_cnt <= pwr_cnt + 10'h001;
          if (!sleep_s) begin
            pwr_cnt <= 10'h000;
            pwr <= spi_fault_pkg::PWR_LOW;
          end else if (pwr_cnt == spi_fault_pkg::WAKE_CYC) begin
            pwr <= spi_fault_pkg::PWR_RUN;
          end
        end
        default: begin
          pwr <= spi_fault_pkg::PWR_RUN;
          pwr_cnt <= 10'h000;
        end
      endcase
    end
  end

  // ==========================================================
  // Serial shifter
  logic active;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [4:0] bit_cnt;
  logic sdo;
  logic sdo_oe;
  logic [7:0] chip_byte;
  logic [7:0] stat1_byte;
  logic [7:0] second_status_reg_byte;
  logic [7:0] cfg [spi_fault_pkg::CFG_FIRST:spi_fault_pkg::CFG_LAST];

  assign active = !cs_n_s && link_en;
  assign sclk_rise = sclk_s && !sclk_d;
  assign sclk_fall = !sclk_s && sclk_d;
  assign cs_fall = !cs_n_s && cs_n_d && link_en;
  assign cs_rise = cs_n_s && !cs_n_d && link_en;

  // Register read view, unmapped reads as zero
  function automatic logic [7:0] read_reg(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == spi_fault_pkg::ADDR_CHIP) begin
      v = chip_byte;
    end else if (a == spi_fault_pkg::ADDR_STAT1) begin
      v = stat1_byte;
    end else if (a == spi_fault_pkg::ADDR_SECOND_STATUS_REG) begin
      v = second_status_reg_byte;
    end else if (a <= spi_fault_pkg::ADDR_MAX) begin
      v = cfg[a];
    end
    return v;
  endfunction

  // Receive on falling edges, MSB first
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (cs_fall) begin
      rx <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (active && sclk_fall) begin
      rx <= {rx[14:0], sdi_s};
      if (bit_cnt != 5'h1f) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // Send on rising edges; data byte fetched once address is in
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tx <= 16'h0000;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= active;
      if (cs_fall) begin
        tx <= {chip_byte, 8'h00};
        sdo <= 1'b0;
      end else if (active && sclk_rise) begin
        sdo <= tx[15];
        tx <= {tx[14:0], 1'b0};
      end else if (active && sclk_fall && bit_cnt == 5'h06) begin
        // Seven shifts done, low byte now sits at 14:7
        tx[14:7] <= read_reg({rx[4:0], sdi_s});
      end
    end
  end

  assign LINK.sdo = sdo;
  assign LINK.sdo_oe = sdo_oe;

  // ==========================================================
  // Frame checks and register writes
  wire logic [5:0] rx_addr = rx[spi_fault_pkg::ADDR_HI:spi_fault_pkg::ADDR_LO];
  wire logic len_ok = (bit_cnt == spi_fault_pkg::FRAME_LEN);
  wire logic addr_ok = (rx_addr <= spi_fault_pkg::ADDR_MAX);
  wire logic par_ok = ~^rx;
  wire logic do_write = cs_rise && len_ok && addr_ok && par_ok &&
                        !rx[spi_fault_pkg::RW_POS] &&
                        (rx_addr >= spi_fault_pkg::ADDR_CTRL);
  wire logic frame_err = cs_rise && !len_ok;
  wire logic addr_err = cs_rise && len_ok && !addr_ok;
  wire logic sleeping = (pwr == spi_fault_pkg::PWR_SLEEP);
  logic clr_cmd;
  logic clr;

  assign clr = clr_cmd || rst_pulse;

  // Configuration storage, defaults on sleep
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = spi_fault_pkg::CFG_FIRST; i <= spi_fault_pkg::CFG_LAST;
           i++) begin
        cfg[i] <= spi_fault_pkg::REG_DEFAULT;
      end
      clr_cmd <= 1'b0;
    end else if (sleeping) begin
      for (int i = spi_fault_pkg::CFG_FIRST; i <= spi_fault_pkg::CFG_LAST;
           i++) begin
        cfg[i] <= spi_fault_pkg::REG_DEFAULT;
      end
      clr_cmd <= 1'b0;
    end else begin
      clr_cmd <= do_write && (rx_addr == spi_fault_pkg::ADDR_CTRL) &&
                 rx[spi_fault_pkg::CTRL_CLR_BIT];
      if (do_write) begin
        cfg[rx_addr] <= rx[7:0];
        if (rx_addr == spi_fault_pkg::ADDR_CTRL) begin
          cfg[rx_addr][spi_fault_pkg::CTRL_CLR_BIT] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Fault flags, set wins over clear
  wire logic [7:0] ctrl = cfg[spi_fault_pkg::CFG_FIRST];
  wire logic wrep = ctrl[spi_fault_pkg::CTRL_WREP_BIT];
  wire logic [1:0] lock_mode = ctrl[spi_fault_pkg::CTRL_LOCK_LO +: 2];
  wire logic lock_set = lock_s && !drv_s &&
                        (lock_mode != spi_fault_pkg::LOCK_OFF);
  logic warn_flag;
  logic shut_flag;
  logic therm_flag;
  logic fault_flag;
  logic stall_flag;
  logic lock_shut;
  logic frame_flag;
  logic addr_flag;

  // Thermal and lock flags
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      {warn_flag, shut_flag, therm_flag, fault_flag} <= 4'h0;
      {stall_flag, lock_shut} <= 2'h0;
    end else if (sleeping) begin
      {warn_flag, shut_flag, therm_flag, fault_flag} <= 4'h0;
      {stall_flag, lock_shut} <= 2'h0;
    end else begin
      warn_flag <= warn_s || (warn_flag && !clr);
      shut_flag <= shut_s || (shut_flag && !clr);
      therm_flag <= warn_s || shut_s || (therm_flag && !clr);
      fault_flag <= shut_s || lock_set || (fault_flag && !clr);
      stall_flag <= lock_set || (stall_flag && !clr);
      lock_shut <= (lock_set && lock_mode == spi_fault_pkg::LOCK_LATCH) ||
                   (lock_shut && !(clr && !lock_s));
    end
  end

  // Serial error flags
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      frame_flag <= 1'b0;
      addr_flag <= 1'b0;
    end else if (sleeping) begin
      frame_flag <= 1'b0;
      addr_flag <= 1'b0;
    end else begin
      frame_flag <= frame_err || (frame_flag && !clr);
      addr_flag <= addr_err || (addr_flag && !clr);
    end
  end

  // Status bytes
  always_comb begin
    chip_byte = 8'h00;
    stat1_byte = 8'h00;
    second_status_reg_byte = 8'h00;
    chip_byte[spi_fault_pkg::CHIP_STALL] = stall_flag;
    chip_byte[spi_fault_pkg::CHIP_SPI] = frame_flag || addr_flag;
    chip_byte[spi_fault_pkg::CHIP_THERM] = therm_flag;
    chip_byte[spi_fault_pkg::CHIP_FAULT] = fault_flag;
    stat1_byte[spi_fault_pkg::STAT1_WARN] = warn_flag;
    stat1_byte[spi_fault_pkg::STAT1_SHUT] = shut_flag;
    second_status_reg_byte[spi_fault_pkg::SECOND_STATUS_REG_FRAME] = frame_flag;
    second_status_reg_byte[spi_fault_pkg::SECOND_STATUS_REG_ADDR] = addr_flag;
  end

  // ==========================================================
  // Power and fault outputs
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FAULT_N_O <= 1'b1;
      SWITCH_EN_O <= 1'b0;
      PUMP_EN_O <= 1'b0;
      SUPPLY_EN_O <= 1'b0;
      SLEEPING_O <= 1'b0;
    end else begin
      FAULT_N_O <= !(in_transition || shut_s || (wrep && warn_s) ||
                     (stall_flag && !drv_s));
      SWITCH_EN_O <= (pwr == spi_fault_pkg::PWR_RUN) && !drv_s &&
                     !shut_s && !lock_shut;
      PUMP_EN_O <= link_en && !shut_s;
      SUPPLY_EN_O <= !sleeping;
      SLEEPING_O <= sleeping;
    end
  end

endmodule

/* File: core/spi_fault_ctrl.sv */
`timescale 1ns/1ns
module spi_fault_ctrl (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Command port
  input wire logic [1:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  // Serial link
  spi_link_if.ctrl LINK
);

  // ==========================================================
  // Returned data synchroniser
  logic sdo_meta;
  logic sdo_s;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sdo_meta <= 1'b0;
      sdo_s <= 1'b0;
    end else begin
      sdo_meta <= LINK.sdo;
      sdo_s <= sdo_meta;
    end
  end

  // ==========================================================
  // Sleep pin and wake wait
  logic sleep_n;
  logic [9:0] wake_cnt;
  wire logic sleep_wr = WR_I && (ADDR_I == spi_fault_pkg::CREG_SLEEP);

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sleep_n <= 1'b1;
      wake_cnt <= 10'h000;
    end else begin
      if (sleep_wr) begin
        sleep_n <= WDATA_I[0];
      end
      if (sleep_wr && WDATA_I[0] && !sleep_n) begin
        wake_cnt <= spi_fault_pkg::WAKE_CYC;
      end else if (wake_cnt != 10'h000) begin
        wake_cnt <= wake_cnt - 10'h001;
      end
    end
  end

  // ==========================================================
  // Frame sequencer
  spi_fault_pkg::link_state_t st;
  logic [9:0] tmr;
  logic [4:0] nbits;
  logic [15:0] txw;
  logic [15:0] rxw;
  logic cs_n;
  logic sclk;
  logic sdi;
  wire logic busy = (st != spi_fault_pkg::LNK_IDLE) ||
                    (wake_cnt != 10'h000) || !sleep_n;
  wire logic start = WR_I && (ADDR_I == spi_fault_pkg::CREG_TX) && !busy;
  wire logic tmr_done = (tmr == 10'h000);

  // Clock divider, select and shifting
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st <= spi_fault_pkg::LNK_IDLE;
      tmr <= 10'h000;
      nbits <= 5'h00;
      txw <= 16'h0000;
      rxw <= 16'h0000;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sdi <= 1'b0;
    end else begin
      if (!tmr_done) begin
        tmr <= tmr - 10'h001;
      end
      case (st)
        spi_fault_pkg::LNK_IDLE: begin
          if (start) begin
            txw <= {WDATA_I[15:9], ^{WDATA_I[15:9], WDATA_I[7:0]},
                    WDATA_I[7:0]};
            cs_n <= 1'b0;
            nbits <= 5'h00;
            tmr <= spi_fault_pkg::HALF_CYC;
            st <= spi_fault_pkg::LNK_LEAD;
          end
        end
        spi_fault_pkg::LNK_LEAD, spi_fault_pkg::LNK_LOW: begin
          if (tmr_done) begin
            if (nbits == spi_fault_pkg::FRAME_LEN) begin
              cs_n <= 1'b1;
              tmr <= spi_fault_pkg::GAP_CYC;
              st <= spi_fault_pkg::LNK_GAP;
            end else begin
              sclk <= 1'b1;
              sdi <= txw[15];
              txw <= {txw[14:0], 1'b0};
              tmr <= spi_fault_pkg::HALF_CYC;
              st <= spi_fault_pkg::LNK_HIGH;
            end
          end
        end
        spi_fault_pkg::LNK_HIGH: begin
          if (tmr_done) begin
            sclk <= 1'b0;
            rxw <= {rxw[14:0], sdo_s};
            nbits <= nbits + 5'h01;
            tmr <= spi_fault_pkg::HALF_CYC;
            st <= spi_fault_pkg::LNK_LOW;
          end
        end
        spi_fault_pkg::LNK_GAP: begin
          if (tmr_done) begin
            st <= spi_fault_pkg::LNK_IDLE;
          end
        end
        default: begin
          st <= spi_fault_pkg::LNK_IDLE;
          cs_n <= 1'b1;
          sclk <= 1'b0;
        end
      endcase
    end
  end

  assign LINK.cs_n = cs_n;
  assign LINK.sclk = sclk;
  assign LINK.sdi = sdi;
  assign LINK.sleep_n = sleep_n;

  // ==========================================================
  // Read port, data only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        spi_fault_pkg::CREG_RX: RDATA_O <= rxw;
        spi_fault_pkg::CREG_STAT: RDATA_O <= {14'h0000, sleep_n, busy};
        spi_fault_pkg::CREG_SLEEP: RDATA_O <= {15'h0000, sleep_n};
        default: RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

endmodule

/* File: verification/spi_fault_monitor.sv */
`timescale 1ns/1ns
// ============================================================
// Link protocol checker
module spi_fault_monitor (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sleep_n
);
  localparam int GAP = 100;
  localparam int WAKE = 500;
  logic [9:0] gap;
  logic [9:0] wake;
  logic [4:0] bits;
  logic sclk_q;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  // Cycles spent with select high
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) gap <= 10'h3ff;
    else if (!cs_n) gap <= 10'h000;
    else if (gap != 10'h3ff) gap <= gap + 10'h001;
  end

  // Cycles since the sleep pin rose
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) wake <= 10'h3ff;
    else if (!sleep_n) wake <= 10'h000;
    else if (wake != 10'h3ff) wake <= wake + 10'h001;
  end

  // Serial clock rises within a frame
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bits <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n) bits <= 5'h00;
      else if (sclk && !sclk_q) bits <= bits + 5'h01;
    end
  end

  // ============================================================
  // Properties
  sequence s_low_held;
    (!sclk && !cs_n)[*8];
  endsequence

  a_select_sclk: assert property ($changed(cs_n) |-> !sclk)
    else $error("serial clock high at select edge");
  a_select_gap: assert property ($fell(cs_n) |-> gap >= GAP)
    else $error("select gap too short");
  a_wake_wait: assert property ($fell(cs_n) |-> wake >= WAKE)
    else $error("frame started inside wake delay");
  a_frame_bits: assert property ($rose(cs_n) |-> bits == 5'h10)
    else $error("frame not sixteen clocks");
  a_idle_float: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("output driven while deselected");
  a_oe_answer: assert property ($fell(cs_n) |-> ##[1:12] sdo_oe)
    else $error("device never drove reply");
  a_sdo_hold: assert property (s_low_held |-> $stable(sdo))
    else $error("reply changed away from rising edge");
  a_sdi_launch: assert property (
    $changed(sdi) && !cs_n && !$fell(cs_n) |-> $rose(sclk))
    else $error("data changed away from rising edge");
endmodule

/* File: verification/test_spi_fault_control_interface.sv */
`timescale 1ns/1ns
// ============================================================
// Bench for both link ends
module test_spi_fault_control_interface;
  logic clk;
  logic nrst;
  logic [1:0] addr;
  logic [15:0] wdata;
  logic wr, rd, drv, twarn, tshut, lock;
  logic [15:0] rdata;
  logic fault_n, sw_en, pump_en, sup_en, sleeping;
  logic [3:0] pins;
  logic [7:0] m [0:15];
  logic [15:0] lf;
  logic [15:0] r;
  int err_total = 0;
  int checks = 0;

  spi_link_if link ();
  spi_link_if l2 ();
  spi_fault_ctrl spi_fault_ctrl_inst (.CLK_I(clk), .NRST_I(nrst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .LINK(link.ctrl));
  spi_fault_device spi_fault_device_inst (.CLK_I(clk), .NRST_I(nrst),
    .LINK(link.device), .DRV_DISABLE_I(drv), .THERM_WARN_I(twarn),
    .THERM_SHUT_I(tshut), .LOCK_EVENT_I(lock), .FAULT_N_O(fault_n),
    .SWITCH_EN_O(sw_en), .PUMP_EN_O(pump_en), .SUPPLY_EN_O(sup_en),
    .SLEEPING_O(sleeping));
  spi_fault_device spi_fault_device_inst2 (.CLK_I(clk), .NRST_I(nrst),
    .LINK(l2.device), .DRV_DISABLE_I(1'b0), .THERM_WARN_I(1'b0),
    .THERM_SHUT_I(1'b0), .LOCK_EVENT_I(1'b0), .FAULT_N_O(),
    .SWITCH_EN_O(), .PUMP_EN_O(), .SUPPLY_EN_O(), .SLEEPING_O());
  spi_fault_monitor spi_fault_monitor_inst (.CLK_I(clk), .NRST_I(nrst),
    .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
    .sdo_oe(link.sdo_oe), .sleep_n(link.sleep_n));
  assign pins = {fault_n, sw_en, pump_en, sup_en};

  // ============================================================
  // Helpers
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] par(logic [15:0] w);
    return {w[15:9], ^{w[15:9], w[7:0]}, w[7:0]};
  endfunction
  task cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e, input logic [15:0] k);
    checks++;
    if ((g & k) !== (e & k)) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task wrc(input logic [1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    cy(1);
    wr <= 1'b0;
  endtask
  task rdc(input logic [1:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    cy(1);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    cy(1);
  endtask
  task idle();
    for (int i = 0; i < 3000; i++) begin
      rdc(spi_fault_pkg::CREG_STAT, r);
      if (r[0] === 1'b0) return;
    end
    chk(r, 16'h0000, 16'h0001);
  endtask
  // One frame through the controller, compared with the model
  task go(input logic w, input logic [5:0] a, input logic [7:0] d,
    input logic [15:0] k);
    logic [15:0] g;
    idle();
    wrc(spi_fault_pkg::CREG_TX, {w, a, 1'b0, d});
    cy(2);
    idle();
    rdc(spi_fault_pkg::CREG_RX, g);
    chk(g, {m[0], a > 6'h0c ? 8'h00 : m[a[3:0]]}, k);
    if (a > 6'h0c) begin
      m[0][5] = 1'b1;
      m[2][0] = 1'b1;
    end else if (!w && a > 6'h02) m[a[3:0]] = d & {7'h7f, a != 6'h03};
    if (!w && a == 6'h03 && d[0]) {m[0], m[1], m[2]} = 24'h000000;
  endtask
  // Bit-banged frame of any length on the second link
  task bb(input logic [15:0] w, input int n);
    l2.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      cy(20);
      l2.sclk <= 1'b1;
      l2.sdi <= w[15 - (i % 16)];
      cy(20);
      l2.sclk <= 1'b0;
      r = {r[14:0], l2.sdo};
    end
    cy(20);
    l2.cs_n <= 1'b1;
    cy(110);
  endtask
  task complete_run();
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ============================================================
  // Clock, watchdog and scenarios
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    {wr, rd, drv, twarn, tshut, lock} = 6'h00;
    {l2.cs_n, l2.sleep_n, l2.sclk, l2.sdi} = 4'hc;
    lf = 16'h000f;
    foreach (m[i]) m[i] = 8'h00;
    cy(10);
    nrst <= 1'b1;
    cy(2);
    for (int a = 0; a < 13; a++) go(1'b1, 6'(a), 8'h00, 16'hffff);
    for (int a = 1; a < 13; a++) begin
      lf = nxt(lf);
      go(1'b0, 6'(a), lf[7:0], 16'hffff); // Old data back
    end
    for (int a = 0; a < 13; a++) go(1'b1, 6'(a), 8'h00, 16'hffff);
    go(1'b0, 6'h0d, 8'h11, 16'hff00); // Bad address
    go(1'b0, 6'h3f, 8'h22, 16'hff00); // Bad address
    go(1'b1, 6'h02, 8'h00, 16'hfeff); // Address flag
    go(1'b1, 6'h0c, 8'h00, 16'h00ff); // Untouched
    go(1'b0, 6'h03, 8'h01, 16'h00ff); // Clear
    go(1'b1, 6'h02, 8'h00, 16'hffff); // Flags gone
    // Thermal warning with and without reporting
    go(1'b0, 6'h03, 8'h00, 16'h00ff);
    twarn <= 1'b1;
    cy(10);
    chk(16'(pins), 16'h000f, 16'h0008); // Silent
    {m[0][1], m[1][7]} = 2'h3;
    go(1'b1, 6'h01, 8'h00, 16'hfeff); // Warning flags
    go(1'b0, 6'h03, 8'h02, 16'h00ff);
    cy(10);
    chk(16'(pins), 16'h0000, 16'h0008); // Reported
    twarn <= 1'b0;
    cy(10);
    chk(16'(pins), 16'h0008, 16'h0008); // Released
    go(1'b1, 6'h01, 8'h00, 16'h00ff); // Still latched
    go(1'b0, 6'h03, 8'h01, 16'h00ff);
    go(1'b1, 6'h01, 8'h00, 16'hffff); // Cleared
    // Thermal shutdown
    tshut <= 1'b1;
    cy(10);
    chk(16'(pins), 16'h0001, 16'h000f); // Off
    {m[0], m[1]} = 16'h0340;
    go(1'b1, 6'h01, 8'h00, 16'hffff); // Shutdown flags
    tshut <= 1'b0;
    cy(10);
    chk(16'(pins), 16'h000f, 16'h000f); // Resumes
    go(1'b1, 6'h01, 8'h00, 16'h00ff); // Latched
    go(1'b0, 6'h03, 8'h01, 16'h00ff);
    // Stall events, response off then latched
    go(1'b0, 6'h03, 8'h0c, 16'hffff);
    lock <= 1'b1;
    cy(10);
    chk(16'(pins), 16'h000f, 16'h000f); // Ignored
    go(1'b1, 6'h00, 8'h00, 16'hffff); // No flag
    lock <= 1'b0;
    go(1'b0, 6'h03, 8'h00, 16'hffff);
    lock <= 1'b1; // Short lock pulse
    cy(10);
    lock <= 1'b0;
    cy(10);
    chk(16'(pins), 16'h0000, 16'h000c); // Held off
    m[0] = 8'h81;
    go(1'b1, 6'h00, 8'h00, 16'hffff); // Stall flag
    go(1'b0, 6'h03, 8'h01, 16'h00ff);
    cy(10);
    chk(16'(pins), 16'h000f, 16'h000f); // Restarted
    // Stall in report mode: flags and fault, switches stay on
    go(1'b0, 6'h03, 8'h04, 16'h00ff);
    lock <= 1'b1;
    cy(10);
    lock <= 1'b0;
    cy(10);
    chk(16'(pins), 16'h0004, 16'h000c); // Report only
    m[0] = 8'h81;
    go(1'b0, 6'h03, 8'h01, 16'hffff); // Report flags
    // Driver disable
    drv <= 1'b1;
    cy(10);
    chk(16'(pins), 16'h0001, 16'h0005); // Switches off
    go(1'b1, 6'h04, 8'h00, 16'h00ff); // Link alive
    drv <= 1'b0;
    // Reset pulse, then full sleep
    go(1'b0, 6'h20, 8'h00, 16'hff00);
    wrc(spi_fault_pkg::CREG_SLEEP, 16'h0000);
    cy(100);
    wrc(spi_fault_pkg::CREG_SLEEP, 16'h0001);
    {m[0], m[2]} = 16'h0000;
    go(1'b1, 6'h02, 8'h00, 16'hffff); // Flags cleared
    go(1'b1, 6'h04, 8'h00, 16'hffff); // Settings kept
    wrc(spi_fault_pkg::CREG_SLEEP, 16'h0000);
    rdc(spi_fault_pkg::CREG_STAT, r);
    chk(r, 16'h0001, 16'h0003); // Pin low, busy
    cy(300);
    chk(16'(pins), 16'h0000, 16'h0008); // Fault held low
    cy(300);
    chk({11'h000, sleeping, pins}, 16'h0010, 16'h0015); // Asleep
    wrc(spi_fault_pkg::CREG_SLEEP, 16'h0001);
    cy(300);
    chk(16'(pins), 16'h0000, 16'h0008); // Low while waking
    cy(300);
    chk(16'(pins), 16'h000f, 16'h000f); // Awake
    for (int a = 3; a < 13; a++) m[a] = 8'h00;
    for (int a = 3; a < 13; a++) go(1'b1, 6'(a), 8'h00, 16'hffff);
    // Short and long frames on the second link
    for (int k = 0; k < 2; k++) begin
      bb(par(16'h085a), k ? 17 : 8); // Wrong length
      bb(par(16'h8400), 16);
      chk(r, 16'h2002, 16'hfeff); // Frame flag
      bb(par(16'h8800), 16);
      chk(r, 16'h0000, 16'h00ff); // Discarded
      l2.sleep_n <= 1'b0;
      cy(100);
      l2.sleep_n <= 1'b1;
      cy(600);
    end
    complete_run();
  end
endmodule
